// *** sapd_defines.svh ***
// Constants for the service acknowledge priority and chain block
`ifndef SAPD_DEFINES_SVH
`define SAPD_DEFINES_SVH
`define SAPD_CFG_RESET 8'h00
`define SAPD_BIT_PRI_SEL 0
`define SAPD_BIT_AUTO_PRI 1
`define SAPD_BIT_RESERVED 2
`define SAPD_BIT_FAIR_OVR 3
`define SAPD_BIT_GLOB_PRI 4
`define SAPD_BIT_CHAIN_EN 5
`define SAPD_BIT_REG_ACK_EN 6
`define SAPD_BIT_PKG_TYPE 7
`define SAPD_WRITE_MASK 8'h7B
`define SAPD_MOD_NONE 3'h0
`define SAPD_MOD_MODEM 3'h1
`define SAPD_MOD_TX 3'h2
`define SAPD_MOD_RX 3'h3
`endif

// *** sapd_pkg.sv ***
// Types for the service acknowledge priority and chain block
package sapd_pkg;
   typedef enum logic [1:0] {
      SAPD_LVL_NONE = 2'b00,
      SAPD_LVL_MODEM = 2'b01,
      SAPD_LVL_TX = 2'b10,
      SAPD_LVL_RX = 2'b11
   } sapd_level_t;

   typedef enum logic [1:0] {
      SAPD_IDLE = 2'b00,
      SAPD_BUSY = 2'b01
   } sapd_state_t;

   // One acknowledgment cycle request
   typedef struct packed {
      logic valid;
      logic by_reg;
      sapd_level_t kind;
   } sapd_ack_req_t;

   // Result of one acknowledgment cycle
   typedef struct packed {
      logic taken;
      logic pass;
      sapd_level_t level;
      logic [7:0] vector;
   } sapd_ack_res_t;

   typedef struct packed {
      sapd_state_t state;
      logic [7:0] cfg;
      logic [7:0] cyc_cfg;
      sapd_ack_res_t res;
      logic [7:0] rd_data;
      logic rd_valid;
   } sapd_state_s_t;
endpackage : sapd_pkg

// *** sapd_core.sv ***
// Service acknowledge decode, priority select and chain pass logic
// Function
// - Chain on, register ack, nothing pending of that kind: assert ack-out.
// - Ack arriving on chain input is handled as a hardware acknowledgment.
// - Chain off, register ack, nothing pending: vector modification code 000.
// - That case is taken locally, not passed, at level 00.
// - Register acknowledgments are accepted only while register-ack enable is 1.
// - Chain-enable bit leaves hardware ack-in to ack-out chaining unchanged.
// - Auto priority with global bit set judges from external request lines.
// - Auto priority with global bit clear judges from own internal requests.
// - Auto priority applies only to type 1 acknowledgments, either path.
// - Wire-ORed request lines make global view meaningless; local is advised.
// - Local auto priority with nothing pending chains a hardware ack on, or a register ack with chain on.
// - Fairness override 1 forces every fair bit to 1; 0 leaves fairness.
// - Transmit and receive acknowledgments stay specific under auto priority.
// - Priority select 0 ranks receive first, 1 transmit; modem always last.
// - Register ack enable 0 refuses register acks; read data undefined.
// - Chain on and request pending: drive global vector modified by type.
// - Configuration resets to zero and is host readable and writable.
`timescale 1ns/1ps
`include "sapd_defines.svh"

module sapd_core
   import sapd_pkg::*;
#(
   parameter int CHANNELS = 8
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_B_I,
   // Configuration register port
   input wire logic CFG_WR_I,
   input wire logic CFG_RD_I,
   input wire logic [7:0] CFG_WDATA_I,
   output logic [7:0] CFG_RDATA_O,
   output logic CFG_RVALID_O,
   // Acknowledgment request
   input wire sapd_ack_req_t ACK_REQ_I,
   input wire logic ACK_CHAIN_IN_N_I,
   // Request states and vector
   input wire logic [2:0] INT_REQ_I,
   input wire logic [2:0] EXTERNAL_REQUEST_VIEW_I,
   input wire logic [7:0] GLOBAL_VECTOR_I,
   input wire logic [CHANNELS-1:0] FAIR_BITS_I,
   // Results
   output sapd_ack_res_t ACK_RES_O,
   output logic ACK_CHAIN_OUT_N_O,
   output logic [CHANNELS-1:0] FAIR_BITS_O,
   output logic [7:0] CFG_O
);
   // Elaboration check; the fair-bit path needs at least one channel
   if (CHANNELS < 1 || CHANNELS > 64) begin : g_bad_channels
      $error("CHANNELS out of range");
   end

   sapd_state_s_t st;
   sapd_state_s_t next_st;
   sapd_ack_req_t req;
   logic hw_ack;

   // ----------------------------------------
   // Priority pick
   // ----------------------------------------
   // Returns the top pending type; NONE when nothing is pending
   function automatic sapd_level_t pick(input logic [2:0] rq, input logic sel);
      if (sel ? rq[1] : rq[2]) begin
         pick = sel ? SAPD_LVL_TX : SAPD_LVL_RX;
      end else if (sel ? rq[2] : rq[1]) begin
         pick = sel ? SAPD_LVL_RX : SAPD_LVL_TX;
      end else if (rq[0]) begin
         pick = SAPD_LVL_MODEM;
      end else begin
         pick = SAPD_LVL_NONE;
      end
   endfunction : pick

   function automatic logic pending(input logic [2:0] rq, input sapd_level_t k);
      case (k)
         SAPD_LVL_MODEM: pending = rq[0];
         SAPD_LVL_TX: pending = rq[1];
         SAPD_LVL_RX: pending = rq[2];
         default: pending = 1'b0;
      endcase
   endfunction : pending

   // Register acks count only while enabled; chain acks always count
   function automatic logic accepted(input sapd_ack_req_t r, input logic [7:0] cfg);
      accepted = r.valid && (!r.by_reg || cfg[`SAPD_BIT_REG_ACK_EN]);
   endfunction : accepted

   // chain input acts as a hardware ack
   assign hw_ack = !ACK_CHAIN_IN_N_I;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [7:0] c;
      logic [2:0] view;
      sapd_level_t lvl;
      logic have;
      c = st.cfg;
      view = 3'h0;
      lvl = SAPD_LVL_NONE;
      have = 1'b0;
      req = ACK_REQ_I;
      next_st = st;
      next_st.rd_valid = 1'b0;
      // host read and write of configuration
      if (CFG_WR_I) begin
         // reserved and package bits are not stored
         next_st.cfg = CFG_WDATA_I & `SAPD_WRITE_MASK;
      end
      if (CFG_RD_I) begin
         next_st.rd_data = st.cfg;
         next_st.rd_valid = 1'b1;
      end
      // A register ack and a chain ack in one cycle: only the register ack is served
      if (hw_ack && !req.valid) begin
         req.valid = 1'b1;
         req.by_reg = 1'b0;
      end
      case (st.state)
         SAPD_IDLE: begin
            next_st.res = '0;
            if (accepted(req, c)) begin
               next_st.cyc_cfg = c;
               next_st.state = SAPD_BUSY;
               // global view from external request lines
               // wire-ORed lines shown all set; local view avoids that
               view = c[`SAPD_BIT_GLOB_PRI] ? EXTERNAL_REQUEST_VIEW_I : INT_REQ_I;
               if (c[`SAPD_BIT_AUTO_PRI] && req.kind == SAPD_LVL_MODEM) begin
                  lvl = pick(view, c[`SAPD_BIT_PRI_SEL]);
                  have = (lvl != SAPD_LVL_NONE) && pending(INT_REQ_I, lvl);
               end else begin
                  lvl = req.kind;
                  have = pending(INT_REQ_I, lvl);
               end
               if (have) begin
                  next_st.res.taken = 1'b1;
                  next_st.res.level = lvl;
                  next_st.res.vector = {GLOBAL_VECTOR_I[7:3], 1'b0, lvl};
               end else if (!req.by_reg || c[`SAPD_BIT_CHAIN_EN]) begin
                  // nothing local pending, ack chains on
                  next_st.res.pass = 1'b1;
               end else begin
                  next_st.res.taken = 1'b1;
                  next_st.res.level = SAPD_LVL_NONE;
                  next_st.res.vector = {GLOBAL_VECTOR_I[7:3], `SAPD_MOD_NONE};
               end
            end
         end
         SAPD_BUSY: begin
            // Hold the answer while the request stands
            // Config written now reaches the next cycle only
            if (!req.valid) begin
               next_st.state = SAPD_IDLE;
               next_st.res = '0;
            end
         end
         default: begin
            next_st.state = SAPD_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge CLK_I) begin
      if (!RST_B_I) begin
         st <= '{state: SAPD_IDLE, cfg: `SAPD_CFG_RESET, cyc_cfg: `SAPD_CFG_RESET, default: '0};
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign ACK_RES_O = st.res;
   assign ACK_CHAIN_OUT_N_O = !st.res.pass;
   assign CFG_RDATA_O = st.rd_data;
   assign CFG_RVALID_O = st.rd_valid;
   assign CFG_O = st.cfg;

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_fair
         assign FAIR_BITS_O[g] = FAIR_BITS_I[g] | st.cfg[`SAPD_BIT_FAIR_OVR];
      end
   endgenerate

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);

   refused_ack_a: assert property (
      st.state == SAPD_IDLE && ACK_REQ_I.valid && ACK_REQ_I.by_reg && ACK_CHAIN_IN_N_I
      && !st.cfg[`SAPD_BIT_REG_ACK_EN] |=> st.res == '0)
      else $error("register ack accepted while disabled");
   chain_pass_a: assert property (
      st.state == SAPD_IDLE && ACK_REQ_I.valid && ACK_REQ_I.by_reg && ACK_REQ_I.kind != SAPD_LVL_MODEM
      && st.cfg[`SAPD_BIT_REG_ACK_EN] && st.cfg[`SAPD_BIT_CHAIN_EN] && !pending(INT_REQ_I, ACK_REQ_I.kind)
      |=> !ACK_CHAIN_OUT_N_O)
      else $error("chained ack not passed");
   local_take_a: assert property (
      st.state == SAPD_IDLE && ACK_REQ_I.valid && ACK_REQ_I.by_reg && ACK_REQ_I.kind != SAPD_LVL_MODEM
      && st.cfg[`SAPD_BIT_REG_ACK_EN] && !st.cfg[`SAPD_BIT_CHAIN_EN] && !pending(INT_REQ_I, ACK_REQ_I.kind)
      |=> ACK_RES_O.taken && ACK_RES_O.vector[2:0] == 3'h0 && ACK_CHAIN_OUT_N_O)
      else $error("unchained empty ack not taken with code 000");
   specific_kind_a: assert property (
      $rose(ACK_RES_O.taken) && $past(ACK_REQ_I.kind) != SAPD_LVL_MODEM && $past(ACK_REQ_I.valid)
      |-> ACK_RES_O.level == $past(ACK_REQ_I.kind) || ACK_RES_O.level == SAPD_LVL_NONE)
      else $error("specific ack re-prioritized");
   rx_first_a: assert property (
      st.state == SAPD_IDLE && accepted(req, st.cfg) && req.kind == SAPD_LVL_MODEM
      && st.cfg[`SAPD_BIT_AUTO_PRI] && !st.cfg[`SAPD_BIT_GLOB_PRI] && !st.cfg[`SAPD_BIT_PRI_SEL]
      && INT_REQ_I[2] |=> ACK_RES_O.level == SAPD_LVL_RX)
      else $error("receive not top priority");
   fair_force_a: assert property (
      st.cfg[`SAPD_BIT_FAIR_OVR] |-> &FAIR_BITS_O)
      else $error("fair bits not forced");
   hold_answer_a: assert property (
      st.state == SAPD_BUSY && req.valid |=> $stable(ACK_RES_O))
      else $error("answer changed mid cycle");
   cfg_write_a: assert property (
      CFG_WR_I |=> CFG_O == ($past(CFG_WDATA_I) & `SAPD_WRITE_MASK))
      else $error("config write lost");
   none_take_a: assert property (
      st.state == SAPD_BUSY && st.res.taken && st.res.level == SAPD_LVL_NONE
      |-> !st.cyc_cfg[`SAPD_BIT_CHAIN_EN]
      && st.cyc_cfg[`SAPD_BIT_REG_ACK_EN])
      else $error("level 00 take outside an unchained register ack");
   tx_first_a: assert property (
      st.state == SAPD_IDLE && accepted(req, st.cfg) && req.kind == SAPD_LVL_MODEM
      && st.cfg[`SAPD_BIT_AUTO_PRI] && !st.cfg[`SAPD_BIT_GLOB_PRI] && st.cfg[`SAPD_BIT_PRI_SEL]
      && INT_REQ_I[1] |=> ACK_RES_O.level == SAPD_LVL_TX)
      else $error("transmit not top priority");
   modem_last_a: assert property (
      st.state == SAPD_IDLE && accepted(req, st.cfg) && req.kind == SAPD_LVL_MODEM
      && st.cfg[`SAPD_BIT_AUTO_PRI] && !st.cfg[`SAPD_BIT_GLOB_PRI] && INT_REQ_I == 3'h1
      |=> ACK_RES_O.taken && ACK_RES_O.level == SAPD_LVL_MODEM)
      else $error("modem not served when alone");
   global_pass_a: assert property (
      st.state == SAPD_IDLE && accepted(req, st.cfg) && req.kind == SAPD_LVL_MODEM
      && st.cfg[`SAPD_BIT_AUTO_PRI] && st.cfg[`SAPD_BIT_GLOB_PRI] && EXTERNAL_REQUEST_VIEW_I == 3'h0
      && (!req.by_reg || st.cfg[`SAPD_BIT_CHAIN_EN]) |=> !ACK_CHAIN_OUT_N_O)
      else $error("global view ignored");
   local_view_a: assert property (
      st.state == SAPD_IDLE && accepted(req, st.cfg) && req.kind == SAPD_LVL_MODEM
      && st.cfg[`SAPD_BIT_AUTO_PRI] && !st.cfg[`SAPD_BIT_GLOB_PRI] && INT_REQ_I == 3'h0
      && (!req.by_reg || st.cfg[`SAPD_BIT_CHAIN_EN]) |=> !ACK_CHAIN_OUT_N_O && !ACK_RES_O.taken)
      else $error("local view took an ack with nothing pending");
   hw_chain_a: assert property (
      st.state == SAPD_IDLE && !ACK_CHAIN_IN_N_I && !ACK_REQ_I.valid
      && ACK_REQ_I.kind != SAPD_LVL_MODEM && !pending(INT_REQ_I, ACK_REQ_I.kind)
      |=> !ACK_CHAIN_OUT_N_O)
      else $error("hardware ack not passed");
   rd_data_a: assert property (
      CFG_RD_I |=> CFG_RVALID_O && CFG_RDATA_O == $past(CFG_O))
      else $error("config read wrong");
   vector_mod_a: assert property (
      $rose(ACK_RES_O.taken) && ACK_RES_O.level != SAPD_LVL_NONE
      |-> ACK_RES_O.vector == {$past(GLOBAL_VECTOR_I[7:3]), 1'b0, ACK_RES_O.level})
      else $error("vector not modified by type");
   busy_exit_a: assert property (
      st.state == SAPD_BUSY && !req.valid
      |=> ACK_RES_O == '0 && ACK_CHAIN_OUT_N_O && st.state == SAPD_IDLE)
      else $error("answer not cleared at cycle end");
   reserved_zero_a: assert property (
      !CFG_O[`SAPD_BIT_RESERVED] && !CFG_O[`SAPD_BIT_PKG_TYPE])
      else $error("reserved config bits stored");
   fair_keep_a: assert property (
      !st.cfg[`SAPD_BIT_FAIR_OVR] |-> FAIR_BITS_O == FAIR_BITS_I)
      else $error("fair bits changed without override");

   pass_seen_c: cover property (!ACK_CHAIN_OUT_N_O);
   refused_seen_c: cover property (st.state == SAPD_IDLE && req.valid && req.by_reg && !st.cfg[`SAPD_BIT_REG_ACK_EN]);
   busy_cfg_c: cover property (st.state == SAPD_BUSY && CFG_WR_I);
   take_seen_c: cover property (ACK_RES_O.taken && ACK_RES_O.level == SAPD_LVL_MODEM);
   none_seen_c: cover property (ACK_RES_O.taken && ACK_RES_O.level == SAPD_LVL_NONE);
endmodule : sapd_core

// *** sapd_peer.sv ***
// Upstream and downstream neighbours on the acknowledge chain
`timescale 1ns/1ps

module sapd_peer (
   // Clock
   input wire logic clk_i,
   // Upstream command and downstream observation
   input wire logic hw_ack_i,
   input wire logic chain_out_n_i,
   output logic ack_n_o,
   output int passes_o
);
   logic last_n;

   // Upstream neighbour holds ack-in low for the whole command
   assign ack_n_o = !hw_ack_i;

   initial begin
      passes_o = 0;
      last_n = 1'b1;
   end

   // downstream sees pass
   // Each falling edge of ack-out is one acknowledgment for the next device
   always @(posedge clk_i) begin
      if (last_n && !chain_out_n_i) begin
         passes_o <= passes_o + 1;
      end
      last_n <= chain_out_n_i;
   end
endmodule : sapd_peer

// *** tb.sv ***
// Self-checking bench for the acknowledge priority and chain block
`timescale 1ns/1ps

module tb;
   import sapd_pkg::*;
   typedef struct packed {
      logic [7:0] cfg;
      logic by_reg;
      logic hw;
      logic [1:0] kind;
      logic [2:0] irq;
      logic [2:0] ext;
      logic [3:0] exp;
   } sapd_row_t;

   logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, hw_ack = 1'b0, ack_in_n, chain_out_n, rvalid;
   logic [7:0] wdata = 8'h00, rdata, cfg;
   logic [7:0] fair_out;
   logic [2:0] irq = 3'h0, ext = 3'h0;
   sapd_ack_req_t req = '0;
   sapd_ack_res_t res;
   int num_errors = 0, n_tests = 0, cycles = 0, exp_passes = 0, passes;
   sapd_row_t rows [16] = '{
      '{8'h00, 1'b0, 1'b1, 2'h2, 3'h2, 3'h0, 4'hA},
      '{8'h00, 1'b0, 1'b1, 2'h3, 3'h0, 3'h0, 4'h4},
      '{8'h20, 1'b0, 1'b1, 2'h3, 3'h0, 3'h0, 4'h4},
      '{8'h40, 1'b1, 1'b0, 2'h2, 3'h2, 3'h0, 4'hA},
      '{8'h00, 1'b1, 1'b0, 2'h2, 3'h2, 3'h0, 4'h0},
      '{8'h60, 1'b1, 1'b0, 2'h3, 3'h0, 3'h0, 4'h4},
      '{8'h40, 1'b1, 1'b0, 2'h3, 3'h0, 3'h0, 4'h8},
      '{8'h42, 1'b1, 1'b0, 2'h1, 3'h7, 3'h0, 4'hB},
      '{8'h43, 1'b1, 1'b0, 2'h1, 3'h7, 3'h0, 4'hA},
      '{8'h42, 1'b1, 1'b0, 2'h1, 3'h1, 3'h0, 4'h9},
      '{8'h42, 1'b1, 1'b0, 2'h2, 3'h7, 3'h0, 4'hA},
      '{8'h43, 1'b1, 1'b0, 2'h3, 3'h7, 3'h0, 4'hB},
      '{8'h52, 1'b1, 1'b0, 2'h1, 3'h6, 3'h2, 4'hA},
      '{8'h72, 1'b1, 1'b0, 2'h1, 3'h7, 3'h0, 4'h4},
      '{8'h62, 1'b1, 1'b0, 2'h1, 3'h0, 3'h7, 4'h4},
      '{8'h02, 1'b0, 1'b1, 2'h1, 3'h4, 3'h0, 4'hB}
   };

   sapd_core dut (.CLK_I(clk), .RST_B_I(rst_b), .CFG_WR_I(wr), .CFG_RD_I(rd), .CFG_WDATA_I(wdata),
      .CFG_RDATA_O(rdata), .CFG_RVALID_O(rvalid), .ACK_REQ_I(req), .ACK_CHAIN_IN_N_I(ack_in_n),
      .INT_REQ_I(irq), .EXTERNAL_REQUEST_VIEW_I(ext), .GLOBAL_VECTOR_I(8'hA5), .FAIR_BITS_I(8'h5A),
      .ACK_RES_O(res), .ACK_CHAIN_OUT_N_O(chain_out_n), .FAIR_BITS_O(fair_out), .CFG_O(cfg));
   sapd_peer peer (.clk_i(clk), .hw_ack_i(hw_ack), .chain_out_n_i(chain_out_n), .ack_n_o(ack_in_n),
      .passes_o(passes));

   initial begin
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         finish_test();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   task automatic cfg_write(input logic [7:0] d);
      @(negedge clk);
      wr = 1'b1;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
   endtask : cfg_write

   task automatic ack_start(input logic by_reg, input logic hw, input logic [1:0] kind);
      @(negedge clk);
      req.valid = !hw;
      req.by_reg = by_reg;
      req.kind = sapd_level_t'(kind);
      hw_ack = hw;
      @(negedge clk);
      @(negedge clk);
   endtask : ack_start

   // Expected result: {taken, pass, level}; vector only counts when taken
   task automatic ack_check(input logic [3:0] exp);
      check({4'h0, res.taken, res.pass, res.level}, {4'h0, exp});
      check({7'h0, chain_out_n}, {7'h0, !exp[2]});
      if (exp[3]) begin
         check(res.vector, {5'h14, 1'b0, exp[1:0]});
      end
      @(negedge clk);
      req = '0;
      hw_ack = 1'b0;
      @(negedge clk);
      @(negedge clk);
   endtask : ack_check

   task automatic finish_test();
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      check(cfg, 8'h00);
      check({7'h0, chain_out_n}, 8'h01);
      check({4'h0, res.taken, res.pass, res.level}, 8'h00);
      foreach (rows[i]) begin
         cfg_write(rows[i].cfg);
         irq = rows[i].irq;
         ext = rows[i].ext;
         ack_start(rows[i].by_reg, rows[i].hw, rows[i].kind);
         exp_passes += rows[i].exp[2];
         ack_check(rows[i].exp);
      end
      // Register readback masks the read-only package bit; the reserved bit is written 0
      cfg_write(8'hFB);
      @(negedge clk);
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      check(rdata, 8'h7B);
      check({7'h0, rvalid}, 8'h01);
      cfg_write(8'h08);
      check(fair_out, 8'hFF);
      cfg_write(8'h00);
      check(fair_out, 8'h5A);
      // Settings changed mid-cycle only reach the following cycle
      cfg_write(8'h60);
      irq = 3'h0;
      ack_start(1'b1, 1'b0, 2'h3);
      cfg_write(8'h40);
      exp_passes++;
      ack_check(4'h4);
      ack_start(1'b1, 1'b0, 2'h3);
      ack_check(4'h8);
      // Reset in mid-cycle drops the answer and the configuration
      cfg_write(8'h40);
      irq = 3'h2;
      ack_start(1'b1, 1'b0, 2'h2);
      check({4'h0, res.taken, res.pass, res.level}, 8'h0A);
      rst_b = 1'b0;
      req = '0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      check(cfg, 8'h00);
      check({4'h0, res.taken, res.pass, res.level}, 8'h00);
      check({7'h0, chain_out_n}, 8'h01);
      check(passes[7:0], exp_passes[7:0]);
      finish_test();
   end
endmodule : tb
